// File: hdl/flash_erase_pkg.sv
// Constants, register map and carrier types for the program flash row erase sequencer.
// Assumes a single 20 MHz system clock and an AHB-Lite register port with 32-bit data.
package flash_erase_pkg;

  // Register byte offsets on the AHB-Lite port.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Field positions in the memory control register.
  localparam int CTRL_REGION_LSB = 0;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_ERASE_BIT = 3;
  localparam int CTRL_START_BIT = 4;

  // Field positions in the status and mask registers.
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  // Region select code that points at the program flash region.
  localparam logic [1:0] REGION_PFM = 2'h2;

  // Unlock keys, written in this order to the unlock register.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // Table pointer layout: a 64-byte row takes bits 21:6, bits 5:0 are ignored.
  localparam int ADDR_W = 22;
  localparam int ROW_LSB = 6;
  localparam int ROW_W = ADDR_W - ROW_LSB;
  localparam logic [21:0] FLASH_BYTES = 22'h01_0000;
  localparam int PROT_LSB = 13;
  localparam int PROT_W = 3;

  // Reset values.
  localparam logic [1:0] REGION_RST = 2'h0;
  localparam logic [21:0] ADDR_RST = 22'h00_0000;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Erase time of the internal programming timer and its cycle count.
  localparam int CLK_PERIOD_NS = 50;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 17;

  // Sequencer and unlock states.
  typedef enum logic {ST_IDLE, ST_ERASE} seq_state_t;
  typedef enum logic [1:0] {UL_NONE, UL_KEY1, UL_ARMED} unlock_state_t;

  // Command to the flash array: erase the given row while active is high.
  typedef struct packed {
    logic active;
    logic [ROW_W-1:0] row;
  } erase_cmd_t;

endpackage

// File: hdl/flash_row_erase_sequencer.sv
// Row erase sequencer for on-chip program flash, with an AHB-Lite register port.
// Assumes a zero-wait AHB-Lite master, a flash array that erases while its command is active,
// and protection and abort inputs synchronous to clk.
//
// What this block does
// - Erases one whole row; no single-word erase.
// - Bulk erase only via serial programming port.
// - Row comes from pointer bits 21:6.
// - CPU is halted for the whole erase.
// - Internal timer ends the erase cycle.
// - Protected address: start cleared, no erase, error.
// - Completion clears start, sets done, may interrupt.
// - Write latches and write permit stay unchanged.
// - Interrupted erase sets the write error flag.
// - Start on invalid address sets write error.
// - Start on protected address sets write error.
`timescale 1ns/1ps
module flash_row_erase_sequencer
  import flash_erase_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] protect_map,
  input wire logic abort_event,
  input wire logic serial_prog_active,
  output logic cpu_halt,
  output erase_cmd_t flash_erase,
  output logic irq
);

  // Captured address phase of the current AHB transfer.
  logic wr_pend_r;
  logic [7:0] addr_r;
  // Software-visible control fields.
  logic [1:0] region_select_r;
  logic write_permit_r;
  logic erase_select_r;
  logic start_r;
  // Table pointer, status flags and interrupt mask.
  logic [ADDR_W-1:0] table_pointer_address_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  // Sequencer state, unlock tracker, timer and latched row.
  seq_state_t state_r;
  unlock_state_t unlock_r;
  logic [CNT_W-1:0] cnt_r;
  logic [ROW_W-1:0] row_r;
  // Decoded events of this cycle.
  logic wr_ctrl;
  logic go;
  logic addr_invalid;
  logic addr_protected;
  logic bad_start;
  logic launch;
  logic timer_end;
  logic aborted;
  logic [CNT_W-1:0] last_cnt;

  // The port never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; only write address is needed besides the read mux address.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // A start request is a control write with start set.
  assign wr_ctrl = wr_pend_r && (addr_r == OFS_CTRL);
  // Start is honoured only just after a full unlock, with permit, erase and flash region chosen.
  assign go = wr_ctrl && hwdata[CTRL_START_BIT] && (unlock_r == UL_ARMED) && hwdata[CTRL_PERMIT_BIT] &&
    hwdata[CTRL_ERASE_BIT] && (hwdata[CTRL_REGION_LSB +: 2] == REGION_PFM) && (state_r == ST_IDLE) &&
    !serial_prog_active;
  // Addresses past the flash end are invalid; protected blocks come from the protection map.
  assign addr_invalid = table_pointer_address_r >= FLASH_BYTES;
  assign addr_protected = protect_map[table_pointer_address_r[PROT_LSB +: PROT_W]];
  assign bad_start = go && (addr_invalid || addr_protected);
  assign launch = go && !bad_start;
  // The programming timer alone ends the cycle; an abort cuts it short.
  assign last_cnt = CNT_W'(ERASE_CYCLES - 1);
  assign timer_end = (state_r == ST_ERASE) && (cnt_r == last_cnt) && !abort_event;
  assign aborted = (state_r == ST_ERASE) && abort_event;

  // Unlock tracker: keys must arrive back to back, and any other write disarms it.
  always_ff @(posedge clk) begin
    if (reset) begin
      unlock_r <= UL_NONE;
    end else if (wr_pend_r) begin
      if (addr_r == OFS_UNLOCK && hwdata[7:0] == UNLOCK_KEY1) begin
        unlock_r <= UL_KEY1;
      end else if (addr_r == OFS_UNLOCK && hwdata[7:0] == UNLOCK_KEY2 && unlock_r == UL_KEY1) begin
        unlock_r <= UL_ARMED;
      end else begin
        unlock_r <= UL_NONE;
      end
    end
  end

  // Control fields change only while idle, so permit is never touched by the erase itself.
  always_ff @(posedge clk) begin
    if (reset) begin
      region_select_r <= REGION_RST;
      write_permit_r <= 1'b0;
      erase_select_r <= 1'b0;
    end else if (wr_ctrl && state_r == ST_IDLE) begin
      region_select_r <= hwdata[CTRL_REGION_LSB +: 2];
      write_permit_r <= hwdata[CTRL_PERMIT_BIT];
      erase_select_r <= hwdata[CTRL_ERASE_BIT];
    end
  end

  // Start bit: set when an erase launches, cleared by hardware at its end or on an abort; a refused start never sets it.
  always_ff @(posedge clk) begin
    if (reset) begin
      start_r <= 1'b0;
    end else if (launch) begin
      start_r <= 1'b1;
    end else if (timer_end || aborted) begin
      start_r <= 1'b0;
    end
  end

  // Table pointer; held while erasing since the CPU is halted.
  always_ff @(posedge clk) begin
    if (reset) begin
      table_pointer_address_r <= ADDR_RST;
    end else if (wr_pend_r && addr_r == OFS_ADDR && state_r == ST_IDLE) begin
      table_pointer_address_r <= hwdata[ADDR_W-1:0];
    end
  end

  // Sequencer: one row per start, latched with the low pointer bits masked off.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      row_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r <= ST_ERASE;
            row_r <= table_pointer_address_r[ADDR_W-1:ROW_LSB];
          end
        end
        ST_ERASE: begin
          if (timer_end || aborted) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Internal programming timer counts the erase cycles.
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (state_r == ST_ERASE) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end else begin
      cnt_r <= '0;
    end
  end

  // Sticky status flags; a write of one clears, a set in the same cycle wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= STATUS_RST;
    end else begin
      logic [1:0] clr;
      logic [1:0] set;
      clr = (wr_pend_r && addr_r == OFS_STATUS) ? hwdata[1:0] : 2'h0;
      set = 2'h0;
      set[STAT_DONE_BIT] = timer_end;
      set[STAT_ERR_BIT] = bad_start || aborted;
      status_r <= (status_r & ~clr) | set;
    end
  end

  // Interrupt mask, same layout as status.
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= MASK_RST;
    end else if (wr_pend_r && addr_r == OFS_MASK) begin
      mask_r <= hwdata[1:0];
    end
  end

  // Read mux from registered state; unmapped offsets read zero.
  always_comb begin
    hrdata = 32'h0000_0000;
    unique case (addr_r)
      OFS_CTRL: begin
        hrdata[CTRL_REGION_LSB +: 2] = region_select_r;
        hrdata[CTRL_PERMIT_BIT] = write_permit_r;
        hrdata[CTRL_ERASE_BIT] = erase_select_r;
        hrdata[CTRL_START_BIT] = start_r;
      end
      OFS_ADDR: hrdata[ADDR_W-1:0] = table_pointer_address_r;
      OFS_STATUS: hrdata[1:0] = status_r;
      OFS_MASK: hrdata[1:0] = mask_r;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // Outputs: the CPU stalls for exactly the erase, the array sees active only then; the row stays driven between erases.
  assign cpu_halt = (state_r == ST_ERASE);
  assign flash_erase.active = (state_r == ST_ERASE);
  assign flash_erase.row = row_r;
  assign irq = |(status_r & mask_r);

  // The checks below watch what this block drives, plus the bus write data, abort and serial inputs that it samples.
  // They share the single system clock and are quiet while reset is held.
  // Each one guards a promise that software relies on.
  // Some guard the length of the erase: the timer, not the bus, ends it.
  // Some guard what the array sees: one row, held still for the whole cycle.
  // Some guard the refusal paths: protected or invalid rows never erase.
  // Some guard the status and interrupt bits that report the outcome.
  // An abort is the one event that may end the erase early.
  // That is why the length checks stand back when an abort was sampled.
  // The bench shortens the timer, so the length checks use only a few cycles.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_NO_START_WITHOUT_UNLOCK: assert property (
    (wr_ctrl && hwdata[CTRL_START_BIT] && unlock_r != UL_ARMED) |=> !flash_erase.active && !start_r)
    else $error("Erase started without a completed unlock.");

  AST_ROW_FROM_POINTER: assert property (
    $rose(flash_erase.active) |-> flash_erase.row == $past(table_pointer_address_r[ADDR_W-1:ROW_LSB]))
    else $error("Erased row does not match pointer bits 21:6.");

  AST_ERASE_LASTS: assert property (
    $rose(flash_erase.active) ##0 (!abort_event [*7]) |=> flash_erase.active)
    else $error("Erase ended before the programming timer.");

  AST_TIMER_FULL_COUNT: assert property (
    $fell(flash_erase.active) && !$past(abort_event) |-> $past(cnt_r) == last_cnt)
    else $error("Erase did not run the full timer count.");

  AST_DONE_ON_END: assert property (
    $fell(flash_erase.active) && !$past(abort_event) |-> status_r[STAT_DONE_BIT] && !start_r)
    else $error("Completion did not set done and clear start.");

  AST_PROTECTED_REFUSED: assert property (
    (go && addr_protected) |=> status_r[STAT_ERR_BIT] && !flash_erase.active && !start_r)
    else $error("Protected row was not refused with an error.");

  AST_INVALID_REFUSED: assert property (
    (go && addr_invalid) |=> status_r[STAT_ERR_BIT] && !flash_erase.active)
    else $error("Invalid address was not refused with an error.");

  AST_ABORT_FLAGS_ERROR: assert property (
    (flash_erase.active && abort_event) |=> !flash_erase.active && status_r[STAT_ERR_BIT])
    else $error("Interrupted erase did not flag an error.");

  AST_PERMIT_HELD: assert property (
    flash_erase.active && $past(flash_erase.active) |-> $stable(write_permit_r))
    else $error("Write permit changed during erase.");

  AST_HALT_DURING_ERASE: assert property (
    $rose(flash_erase.active) |-> cpu_halt throughout (flash_erase.active [*2]))
    else $error("CPU was not halted during erase.");

  AST_NO_SELF_ERASE_IN_SERIAL: assert property (
    (wr_ctrl && serial_prog_active && state_r == ST_IDLE) |=> !flash_erase.active)
    else $error("Self erase ran while the serial programming port owns the flash.");

  // Only an accepted start may raise the erase command.
  AST_ERASE_NEEDS_GO: assert property (
    $rose(flash_erase.active) |-> $past(launch))
    else $error("Erase began without an accepted start.");

  // The array must see one row, unchanged for the whole erase.
  AST_ROW_HELD: assert property (
    flash_erase.active && $past(flash_erase.active) |-> $stable(flash_erase.row))
    else $error("Erased row changed during the erase.");

  // The pointer that named the row must not move while erasing.
  AST_POINTER_HELD: assert property (
    flash_erase.active && $past(flash_erase.active) |-> $stable(table_pointer_address_r))
    else $error("Table pointer changed during the erase.");

  // The CPU stall lines up exactly with the erase command.
  AST_HALT_MATCHES_ERASE: assert property (
    cpu_halt == flash_erase.active)
    else $error("CPU halt does not match the erase cycle.");

  // An erase ends only at the last timer count or on an abort.
  AST_END_FROM_TIMER: assert property (
    $fell(flash_erase.active) |-> ($past(cnt_r) == last_cnt) || $past(abort_event))
    else $error("Erase ended without the timer or an abort.");

  // The start bit reads one exactly while the erase runs.
  AST_START_TRACKS_ERASE: assert property (
    start_r == flash_erase.active)
    else $error("Start bit does not follow the erase cycle.");

  // An enabled done flag must raise the interrupt.
  AST_IRQ_ON_DONE: assert property (
    (status_r[STAT_DONE_BIT] && mask_r[STAT_DONE_BIT]) |-> irq)
    else $error("Enabled done flag did not raise the interrupt.");

  // With every enable cleared the interrupt stays low.
  AST_NO_IRQ_WHEN_MASKED: assert property (
    (mask_r == 2'h0) |-> !irq)
    else $error("Interrupt raised with all enables cleared.");

  // An aborted erase must not report completion.
  AST_ABORT_NO_DONE: assert property (
    (flash_erase.active && abort_event && !status_r[STAT_DONE_BIT]) |=> !status_r[STAT_DONE_BIT])
    else $error("Aborted erase reported completion.");

  // A protected row never stalls the CPU.
  AST_PROTECTED_NO_HALT: assert property (
    (go && addr_protected) |=> !cpu_halt)
    else $error("Protected row stalled the CPU.");

endmodule // flash_row_erase_sequencer

// File: sim/flash_row_erase_sequencer_bench.sv
// Self-checking bench for the program flash row erase sequencer.
// Assumes the design's AHB-Lite port, a shortened erase count and level abort and protect inputs.
`timescale 1ns/1ps
module flash_row_erase_sequencer_bench;
  import flash_erase_pkg::*;
  localparam int EC = 16; // Shortened erase time in cycles.
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic abort_event = 1'h0;
  logic serial_prog_active = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] protect_map = 8'h00;
  logic [31:0] rnd = 32'h0000_27ad; // Random state of the feedback register.
  logic [31:0] hrdata, obs_v, q;
  logic hreadyout, hresp, cpu_halt, irq;
  logic [21:0] p; // Table pointer used by the current test.
  erase_cmd_t flash_erase;
  logic [31:0] exp_q[$]; // Expected results, oldest first.
  int err_total = 0;
  int samples_checked = 0;
  int n;
  event got;

  // Clock at 20 MHz.
  initial forever #25 clk = ~clk;

  flash_row_erase_sequencer #(.ERASE_CYCLES(EC)) flash_row_erase_sequencer_inst (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .protect_map(protect_map), .abort_event(abort_event),
    .serial_prog_active(serial_prog_active), .cpu_halt(cpu_halt), .flash_erase(flash_erase), .irq(irq));

  // Fibonacci style feedback register for random pointers.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // One AHB-Lite single word transfer; read data is taken at the falling edge of the data phase cycle in which hready is high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic rdy;
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do begin @(negedge clk); rdy = hreadyout; @(posedge clk); end while (rdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(negedge clk); rdy = hreadyout; r = hrdata; @(posedge clk); end while (rdy !== 1'h1);
  endtask

  // Notes an expectation and hands the observed value to the monitor.
  task automatic check(input logic [31:0] e, input logic [31:0] o);
    exp_q.push_back(e);
    obs_v = o;
    -> got;
    #1;
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000, q);
    check(e, q);
  endtask

  // Full software erase sequence: pointer, region and bits, two keys, then start.
  task automatic go(input logic [21:0] ptr);
    bus(1'h1, OFS_ADDR, {10'h000, ptr}, q);
    bus(1'h1, OFS_CTRL, 32'h0000_000e, q);
    bus(1'h1, OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY1}, q);
    bus(1'h1, OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY2}, q);
    bus(1'h1, OFS_CTRL, 32'h0000_001e, q);
    @(negedge clk);
  endtask

  // Counts cycles while the CPU is halted, with a bound.
  task automatic wait_done(output int c);
    c = 0;
    while (cpu_halt === 1'h1 && c < 200) begin
      c++;
      @(negedge clk);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Monitor: takes the oldest expectation whenever a result appears.
  initial forever begin
    @(got);
    samples_checked++;
    if (obs_v !== exp_q.pop_front()) begin
      err_total++;
      $display("[FAIL] %0t ns: observed value %h differs from expectation", $time, obs_v);
    end
  end

  // Watchdog sized well above the expected run length.
  initial begin
    #(50 * 4000);
    err_total++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    rdchk(OFS_CTRL, 32'h0000_0000);
    rdchk(OFS_ADDR, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0000);
    rdchk(OFS_MASK, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    check({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
    $display("test reset values done");
    rnd = lfsr(rnd);
    p = rnd[21:0] & 22'h00_ffff;
    @(posedge clk);
    protect_map <= ~(8'h01 << p[15:13]);
    bus(1'h1, OFS_MASK, 32'h0000_0001, q);
    go(p);
    check({14'h0000, flash_erase.active, cpu_halt, flash_erase.row}, {14'h0000, 2'h3, p[21:6]});
    wait_done(n);
    check(32'(EC), 32'(n));
    check({31'h0000_0000, irq}, 32'h0000_0001);
    rdchk(OFS_CTRL, 32'h0000_000e);
    rdchk(OFS_ADDR, {10'h000, p});
    rdchk(OFS_STATUS, 32'h0000_0001);
    bus(1'h1, OFS_STATUS, 32'h0000_0001, q);
    @(negedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test row erase done");
    bus(1'h1, OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY1}, q);
    bus(1'h1, OFS_ADDR, {10'h000, p}, q);
    bus(1'h1, OFS_UNLOCK, {24'h00_0000, UNLOCK_KEY2}, q);
    bus(1'h1, OFS_CTRL, 32'h0000_001e, q);
    @(negedge clk);
    check({31'h0000_0000, cpu_halt}, 32'h0000_0000);
    rdchk(OFS_CTRL, 32'h0000_000e);
    @(posedge clk);
    serial_prog_active <= 1'h1;
    go(p);
    check({31'h0000_0000, cpu_halt}, 32'h0000_0000);
    @(posedge clk);
    serial_prog_active <= 1'h0;
    rdchk(OFS_STATUS, 32'h0000_0000);
    $display("test refused starts done");
    @(posedge clk);
    protect_map <= 8'h01 << p[15:13];
    go(p);
    check({31'h0000_0000, cpu_halt}, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0002);
    rdchk(OFS_CTRL, 32'h0000_000e);
    bus(1'h1, OFS_STATUS, 32'h0000_0003, q);
    protect_map <= 8'h00;
    go(22'h01_0000);
    check({31'h0000_0000, cpu_halt}, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0002);
    bus(1'h1, OFS_STATUS, 32'h0000_0003, q);
    $display("test protected and invalid done");
    bus(1'h1, OFS_MASK, 32'h0000_0000, q);
    go(p);
    repeat (3) @(posedge clk);
    abort_event <= 1'h1;
    @(posedge clk);
    abort_event <= 1'h0;
    @(negedge clk);
    check({31'h0000_0000, cpu_halt}, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0002);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test abort done");
    report_and_stop();
  end
endmodule // flash_row_erase_sequencer_bench
